// File: verilog/fdm_host.sv
// host-side controller that drives the flash disk mode sequences
// assumes the device pins are on the board; busy_n is asynchronous
`timescale 1ns/1ps
module fdm_host
  import fdm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // user command port
  input wire fdm_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output logic [1:0] mode_seen,
  // device pins
  output fdm_bus_t bus,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in,
  output logic hw_reset_in_n,
  input wire logic busy_n
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_WR_CTRL, ST_WR_CONF, ST_WAKE_RD, ST_SETTLE_RD,
    ST_RST_PULSE, ST_WAIT_BUSY, ST_GAP
  } fdm_state_t;

  fdm_state_t state_ff, nxt_state;
  fdm_bus_t bus_ff, nxt_bus;
  logic [DATA_W-1:0] dout_ff, nxt_dout;
  logic doe_ff, nxt_doe;
  logic rstn_ff, nxt_rstn;
  logic [1:0] mode_ff, nxt_mode;
  logic [1:0] target_ff, nxt_target;
  logic [7:0] tmr_ff, nxt_tmr;
  logic [2:0] wake_ff, nxt_wake;
  logic busy_s1_ff, busy_s2_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic cmd_ready_ff;

  // idle bus: all strobes negated, nothing driven
  function automatic fdm_bus_t idle_bus();
    fdm_bus_t b;
    b.ce_n = 1'b1;
    b.we_n = 1'b1;
    b.oe_n = 1'b1;
    b.upper_byte_enable_n = 1'b1;
    b.addr = '0;
    return b;
  endfunction

  // one strobe cycle; write asserts ce and we, read asserts ce and oe
  function automatic fdm_bus_t strobe(input logic [12:0] a, input logic wr);
    fdm_bus_t b;
    b.ce_n = 1'b0;
    b.we_n = ~wr;
    b.oe_n = wr;
    b.upper_byte_enable_n = 1'b0;
    b.addr = a;
    return b;
  endfunction

  // two-flop synchroniser on the asynchronous busy pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_s1_ff <= 1'b0;
      busy_s2_ff <= 1'b0;
    end else begin
      busy_s1_ff <= busy_n;
      busy_s2_ff <= busy_s1_ff;
    end
  end

  // captured read data; wake and settle reads are discarded anyway
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (!bus_ff.oe_n && tmr_ff == 8'h01) begin
      rdata_ff <= data_in;
    end
  end

  // sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_bus = bus_ff;
    nxt_dout = dout_ff;
    nxt_doe = doe_ff;
    nxt_rstn = rstn_ff;
    nxt_mode = mode_ff;
    nxt_target = target_ff;
    nxt_tmr = tmr_ff;
    nxt_wake = wake_ff;
    if (tmr_ff != 8'h00) begin
      nxt_tmr = tmr_ff - 8'h01;
    end
    case (state_ff)
      ST_IDLE: begin
        nxt_bus = idle_bus();
        nxt_doe = 1'b0;
        if (cmd_valid) begin
          case (cmd)
            FDM_CMD_NORMAL: begin
              nxt_target = MODE_NORMAL;
              nxt_state = (mode_ff == MODE_PDOWN) ? ST_WAKE_RD : ST_WR_CTRL;
              nxt_wake = 3'h0;
            end
            FDM_CMD_PDOWN: begin
              // power-down entry only from normal mode
              if (mode_ff == MODE_NORMAL) begin
                nxt_target = MODE_PDOWN;
                nxt_state = ST_WR_CTRL;
              end
            end
            FDM_CMD_HWRESET: begin
              nxt_state = ST_RST_PULSE;
              nxt_tmr = 8'(RST_PULSE_CYC);
              nxt_rstn = 1'b0;
              nxt_wake = 3'h0;
            end
            default: begin
              nxt_state = ST_IDLE;
            end
          endcase
          if (cmd == FDM_CMD_NORMAL && mode_ff != MODE_PDOWN) begin
            nxt_bus = strobe(OFS_CTRL, 1'b1);
            nxt_dout = {14'h0000, MODE_NORMAL};
            nxt_doe = 1'b1;
            nxt_tmr = 8'(STROBE_CYC);
          end else if (cmd == FDM_CMD_PDOWN && mode_ff == MODE_NORMAL) begin
            nxt_bus = strobe(OFS_CTRL, 1'b1);
            nxt_dout = {14'h0000, MODE_PDOWN};
            nxt_doe = 1'b1;
            nxt_tmr = 8'(STROBE_CYC);
          end else if (cmd == FDM_CMD_NORMAL) begin
            nxt_bus = strobe(OFS_WAKE, 1'b0);
            nxt_tmr = 8'(STROBE_CYC);
          end
        end
      end
      ST_WR_CTRL: begin
        // the write strobe must fall between the two writes, otherwise the
        // device sees one long cycle and never takes the confirmation
        if (tmr_ff == 8'h00) begin
          if (!bus_ff.ce_n) begin
            nxt_bus = idle_bus();
            nxt_doe = 1'b0;
            nxt_tmr = 8'(STROBE_CYC);
          end else begin
            // confirmation write carries the complement of the mode
            nxt_bus = strobe(OFS_CONFIRM, 1'b1);
            nxt_dout = {14'h3FFF, ~target_ff};
            nxt_doe = 1'b1;
            nxt_tmr = 8'(STROBE_CYC);
            nxt_state = ST_WR_CONF;
          end
        end
      end
      ST_WR_CONF: begin
        if (tmr_ff == 8'h00) begin
          nxt_bus = idle_bus();
          nxt_doe = 1'b0;
          nxt_mode = target_ff;
          nxt_tmr = 8'(STROBE_CYC);
          nxt_state = ST_GAP;
        end
      end
      ST_WAKE_RD: begin
        // strobes are counted, data and address never matter
        if (tmr_ff == 8'h00) begin
          if (bus_ff.ce_n) begin
            nxt_bus = strobe(OFS_WAKE, 1'b0);
            nxt_tmr = 8'(STROBE_CYC);
          end else begin
            nxt_bus = idle_bus();
            nxt_tmr = 8'(STROBE_CYC);
            nxt_wake = wake_ff + 3'h1;
            if (wake_ff + 3'h1 == WAKE_READS) begin
              nxt_state = ST_SETTLE_RD;
            end
          end
        end
      end
      ST_SETTLE_RD: begin
        if (tmr_ff == 8'h00) begin
          if (bus_ff.ce_n) begin
            nxt_bus = strobe(OFS_WAKE, 1'b0);
            nxt_tmr = 8'(STROBE_CYC);
          end else begin
            nxt_bus = idle_bus();
            nxt_mode = MODE_NORMAL;
            nxt_tmr = 8'(STROBE_CYC);
            nxt_state = ST_GAP;
          end
        end
      end
      ST_RST_PULSE: begin
        if (tmr_ff == 8'h00) begin
          nxt_rstn = 1'b1;
          nxt_state = ST_WAIT_BUSY;
        end
      end
      ST_WAIT_BUSY: begin
        // device holds busy while its copier loads boot code
        if (busy_s2_ff) begin
          nxt_mode = MODE_RESET;
          nxt_state = ST_IDLE;
        end
      end
      ST_GAP: begin
        if (tmr_ff == 8'h00) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state registers; after reset the device is assumed in reset mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      bus_ff <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                  upper_byte_enable_n: 1'b1, addr: 13'h0000};
      dout_ff <= 16'h0000;
      doe_ff <= 1'b0;
      rstn_ff <= 1'b1;
      mode_ff <= MODE_RESET;
      target_ff <= MODE_RESET;
      tmr_ff <= 8'h00;
      wake_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      bus_ff <= nxt_bus;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
      rstn_ff <= nxt_rstn;
      mode_ff <= nxt_mode;
      target_ff <= nxt_target;
      tmr_ff <= nxt_tmr;
      wake_ff <= nxt_wake;
    end
  end

  // ready only while idle so a command is never dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_ready_ff <= 1'b0;
    end else begin
      cmd_ready_ff <= (nxt_state == ST_IDLE);
    end
  end

  assign cmd_ready = cmd_ready_ff;
  assign bus = bus_ff;
  assign data_out = dout_ff;
  assign data_oe = doe_ff;
  assign hw_reset_in_n = rstn_ff;
  assign mode_seen = mode_ff;
endmodule

// File: verilog/fdm_pkg.sv
// constants and carrier types for the flash disk mode host controller
// assumes a 50 MHz system clock and an SRAM-like device port
package fdm_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  // device window offsets of the mode registers
  localparam logic [12:0] OFS_CTRL = 13'h1006;
  localparam logic [12:0] OFS_CONFIRM = 13'h1076;
  localparam logic [12:0] OFS_WAKE = 13'h1FFF;
  // control register encodings; this host writes only the normal and power-down ones
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;
  localparam logic [7:0] CTRL_FIELD_SHIFT = 8'h00;
  // wake-up: three dummy reads, then one settle read
  localparam logic [2:0] WAKE_READS = 3'h3;
  // strobe timing
  localparam int CLK_MHZ = 50;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    FDM_CMD_NONE,
    FDM_CMD_NORMAL,
    FDM_CMD_PDOWN,
    FDM_CMD_HWRESET
  } fdm_cmd_t;

  // one host bus cycle toward the device
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic upper_byte_enable_n;
    logic [ADDR_W-1:0] addr;
  } fdm_bus_t;
endpackage

// File: sim/fdm_dev_model.sv
// behavioural flash disk device seen at its host pins
// assumes glitch-free registered strobes; no clock of its own
`timescale 1ns/1ps
module fdm_dev_model
  import fdm_pkg::*;
(
  // host side
  input wire fdm_bus_t bus,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic hw_reset_in_n,
  // answers
  output logic [DATA_W-1:0] data_in,
  output logic busy_n
);
  logic [1:0] mode_ff;
  logic [7:0] ctl_ff;
  logic [2:0] wake_ff;
  wire wr = !bus.ce_n && !bus.we_n;
  wire rd = !bus.ce_n && !bus.oe_n;
  // power-up lands in reset mode
  initial begin
    mode_ff = MODE_RESET;
    ctl_ff = 8'h00;
    wake_ff = 3'h0;
  end
  // power-up and every reset pulse start a download that holds busy low;
  // one process owns busy so power-up and pin reset share one path
  always begin
    busy_n = 1'b0;
    wait (hw_reset_in_n === 1'b1);
    #400 busy_n = 1'b1; // copier has loaded the loader
    @(negedge hw_reset_in_n);
    // reset pin wins over every mode and drops a partial wake count
    mode_ff = MODE_RESET;
    wake_ff = 3'h0;
  end
  // only the mode pair is writable: serial and write-once area have no path
  // from the pins here, so the host can never alter them
  // 1 ns settle since data and strobes land in one update; power-down ignores writes
  always @(posedge wr) begin
    #1;
    if (mode_ff != MODE_PDOWN && bus.addr == OFS_CTRL) begin
      ctl_ff = data_out[7:0];
    end
    if (mode_ff != MODE_PDOWN && bus.addr == OFS_CONFIRM && data_out[7:0] == ~ctl_ff) begin
      mode_ff = ctl_ff[1:0];
    end
  end
  // any read in power-down counts toward wake; buffers back at end of the third
  always @(negedge rd) begin
    if (mode_ff == MODE_PDOWN) begin
      wake_ff = wake_ff + 3'h1;
    end
    if (wake_ff == 3'h3) begin
      mode_ff = MODE_NORMAL;
      wake_ff = 3'h0;
    end
  end
  // reset mode reads zero, normal mode the address; an unselected or asleep bus returns ~data_out
  assign data_in = (rd && mode_ff == MODE_RESET) ? 16'h0000 :
    (rd && mode_ff == MODE_NORMAL) ? {3'h0, bus.addr} : ~data_out;
endmodule

// File: sim/fdm_host_chk.sv
// port checker for the flash disk mode host controller
// assumes one clock domain; bound onto every fdm_host
`timescale 1ns/1ps
module fdm_host_chk
  import fdm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // command side
  input wire fdm_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [1:0] mode_seen,
  // device side
  input wire fdm_bus_t bus,
  input wire logic data_oe,
  input wire logic hw_reset_in_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a command counts only when offered while ready
  wire take = cmd_valid && cmd_ready;
  property p_rd; !bus.oe_n |-> bus.we_n && !bus.ce_n; endproperty
  a_rd: assert property (p_rd) else $error("read strobe bad");
  property p_oe; data_oe |-> bus.oe_n; endproperty
  a_oe: assert property (p_oe) else $error("data driven in read");
  property p_wr;
    !bus.we_n |-> !bus.ce_n && (bus.addr == OFS_CTRL || bus.addr == OFS_CONFIRM);
  endproperty
  a_wr: assert property (p_wr) else $error("write address bad");
  property p_nrm;
    take && cmd == FDM_CMD_NORMAL && mode_seen == MODE_RESET
      |-> ##[1:8] (!bus.we_n && bus.addr == OFS_CTRL);
  endproperty
  a_nrm: assert property (p_nrm) else $error("no control write");
  property p_wak;
    take && cmd == FDM_CMD_NORMAL && mode_seen == MODE_PDOWN
      |-> ##[1:8] (!bus.oe_n && bus.addr == OFS_WAKE);
  endproperty
  a_wak: assert property (p_wak) else $error("no wake read");
  property p_pdi;
    take && cmd == FDM_CMD_PDOWN && mode_seen != MODE_NORMAL |=> bus.we_n [*8];
  endproperty
  a_pdi: assert property (p_pdi) else $error("power-down not refused");
  property p_hwr; take && cmd == FDM_CMD_HWRESET |-> ##[1:8] !hw_reset_in_n; endproperty
  a_hwr: assert property (p_hwr) else $error("no reset pulse");
  property p_pls; $fell(hw_reset_in_n) |=> !hw_reset_in_n [*8]; endproperty
  a_pls: assert property (p_pls) else $error("reset pulse short");
endmodule
bind fdm_host fdm_host_chk u_fdm_host_chk(.sys_clk(sys_clk), .rst(rst), .cmd(cmd),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .mode_seen(mode_seen), .bus(bus),
  .data_oe(data_oe), .hw_reset_in_n(hw_reset_in_n));

// File: sim/tb_top.sv
// self-checking bench for the flash disk mode host controller
// assumes the device model and bound checker are compiled first
`timescale 1ns/1ps
module tb_top;
  import fdm_pkg::*;
  logic sys_clk;
  logic rst;
  fdm_cmd_t cmd;
  logic cmd_valid;
  logic cmd_ready;
  logic [1:0] mode_seen;
  fdm_bus_t bus;
  logic [DATA_W-1:0] data_out;
  logic data_oe;
  logic [DATA_W-1:0] data_in;
  logic hw_reset_in_n;
  logic busy_n;
  int fail_count;
  int total_checks;
  fdm_host u_fdm_host(.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .mode_seen(mode_seen), .bus(bus), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .hw_reset_in_n(hw_reset_in_n), .busy_n(busy_n));
  fdm_dev_model u_fdm_dev_model(.bus(bus), .data_out(data_out),
    .hw_reset_in_n(hw_reset_in_n), .data_in(data_in), .busy_n(busy_n));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // host belief and device state must agree with the expected mode
  task automatic expect_mode(input logic [1:0] m);
    chk("mode_seen", m, mode_seen);
    chk("dev_mode", m, u_fdm_dev_model.mode_ff);
  endtask
  // offer once for one cycle without checking ready, then wait a bounded time for idle
  task automatic send(input fdm_cmd_t c);
    @(posedge sys_clk);
    cmd <= c;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    repeat (3) @(negedge sys_clk);
    for (int n = 0; n < 3000 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
    chk("cmd_ready", 2'h1, {1'b0, cmd_ready});
  endtask
  task automatic t_normal;
    send(FDM_CMD_NORMAL);
    expect_mode(MODE_NORMAL);
    $display("test normal done");
  endtask
  task automatic t_pdown;
    send(FDM_CMD_PDOWN);
    expect_mode(MODE_PDOWN);
    $display("test power-down done");
  endtask
  task automatic t_wake;
    send(FDM_CMD_NORMAL);
    expect_mode(MODE_NORMAL);
    $display("test wake done");
  endtask
  task automatic t_hwreset;
    send(FDM_CMD_HWRESET);
    expect_mode(MODE_RESET);
    chk("busy_n", 2'h1, {1'b0, busy_n});
    $display("test hardware reset done");
  endtask
  task automatic t_refuse;
    send(FDM_CMD_PDOWN);
    send(FDM_CMD_NONE);
    expect_mode(MODE_RESET);
    $display("test refuse done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // the sequence needs well under 2000 cycles
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    cmd = FDM_CMD_NONE;
    cmd_valid = 1'b0;
    fail_count = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (30) @(negedge sys_clk);
    expect_mode(MODE_RESET);
    t_normal();
    t_pdown();
    t_wake();
    t_pdown();
    t_hwreset();
    t_refuse();
    t_normal();
    t_hwreset();
    summarize();
  end
endmodule
